// *** logic/fault_flash_indicator.sv ***
// fault flash code indicator with acknowledge and multi-unit bookkeeping
// Behaviour
// - each code blinks group burst, dark gap, then detail burst
// - errors and warnings use the same group and detail code space
// - pending codes shown one complete code after another
// - after the last pending code, presentation wraps to the first
// - value n blinks n plus one flashes; zero flashes means gap
// - error state holds until cause gone and acknowledge received
// - button, software clear or rising external edge acknowledges
// - remote sense request in series system is refused with an error
// - inter-unit bus supports up to 64 devices
// - address is upper and lower digit; zero address is master
// - master forwards set values; slaves convert them to outputs
// - total requested output divided evenly among units
// - errors blink on red indicator, warnings on yellow indicator
// - sixteen groups of sixteen details, two four-bit values
`timescale 1ns/100ps
`default_nettype none
// flash timings default to the real ones; a bench may shorten them
module fault_flash_indicator #(
  parameter int unsigned ON_CYC = flash_code_pkg::FLASH_ON_CYC,
  parameter int unsigned OFF_CYC = flash_code_pkg::FLASH_OFF_CYC,
  parameter int unsigned GGAP_CYC = flash_code_pkg::GROUP_GAP_CYC,
  parameter int unsigned CGAP_CYC = flash_code_pkg::CODE_GAP_CYC
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [flash_code_pkg::NUM_CODES-1:0] err_cause,
  input wire logic [flash_code_pkg::NUM_CODES-1:0] warn_cause,
  input wire logic ack_button,
  input wire logic ack_soft,
  input wire logic ack_ext_pin,
  input wire logic series_mode,
  input wire logic sense_req,
  input wire logic [3:0] upper_address_digit,
  input wire logic [3:0] lower_address_digit,
  input wire logic [flash_code_pkg::UNIT_CNT_W-1:0] unit_count,
  input wire logic [flash_code_pkg::SETVAL_W-1:0] host_setval,
  input wire logic host_setval_vld,
  input wire logic [flash_code_pkg::SETVAL_W-1:0] link_setval_in,
  input wire logic link_setval_in_vld,
  output logic [flash_code_pkg::SETVAL_W-1:0] link_setval_out,
  output logic link_setval_out_vld,
  output logic [flash_code_pkg::SETVAL_W-1:0] unit_setval,
  output logic is_master,
  output logic sense_enable,
  output logic sense_refused,
  output logic error_state,
  output logic red_led,
  output logic yellow_led
);
  // sense refusal is raised as error code 0xf0, which err_cause bit 0xf0 also sets
  localparam logic [7:0] SENSE_ERR_CODE = 8'hf0;
  localparam int unsigned SETVAL_W = flash_code_pkg::SETVAL_W;

  // external pins pass two flops before use
  logic [2:0] ack_ext_q;
  logic [1:0] btn_sync_q, sense_sync_q, series_sync_q;
  logic [flash_code_pkg::NUM_CODES-1:0] err_latch_q, err_latch_d;
  logic sense_err_q, sense_en_q;
  logic error_q;
  logic [flash_code_pkg::SETVAL_W-1:0] out_q, share_q, unit_q;
  logic out_vld_q;
  logic [flash_code_pkg::NUM_CODES-1:0] err_pend;
  logic [flash_code_pkg::NUM_CODES-1:0] err_now;

  wire ack_edge = ack_ext_q[1] & ~ack_ext_q[2];
  wire ack_any = ack_edge | btn_sync_q[1] | ack_soft;
  wire master_w = (upper_address_digit == 4'h0) &&
    (lower_address_digit == 4'h0);
  wire sense_bad = sense_sync_q[1] & series_sync_q[1];
  wire [flash_code_pkg::UNIT_CNT_W-1:0] units_w =
    (unit_count == '0) ? 7'h01 :
    (unit_count > 7'(flash_code_pkg::MAX_UNITS)) ?
    7'(flash_code_pkg::MAX_UNITS) : unit_count;

  // current causes, including the refused sense request
  always_comb begin
    err_now = err_cause;
    err_now[SENSE_ERR_CODE] = err_cause[SENSE_ERR_CODE] | sense_err_q;
  end

  // latched errors clear only when cause gone and acknowledged; a new
  // cause in the acknowledge cycle wins over the clear
  assign err_latch_d = err_now |
    (err_latch_q & ~{flash_code_pkg::NUM_CODES{ack_any}});
  assign err_pend = err_latch_q | err_now;

  // synchronisers and edge capture
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_ext_q <= 3'h0;
      btn_sync_q <= 2'h0;
      sense_sync_q <= 2'h0;
      series_sync_q <= 2'h0;
    end else begin
      ack_ext_q <= {ack_ext_q[1:0], ack_ext_pin};
      btn_sync_q <= {btn_sync_q[0], ack_button};
      sense_sync_q <= {sense_sync_q[0], sense_req};
      series_sync_q <= {series_sync_q[0], series_mode};
    end
  end

  // error latches and sense decision
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      err_latch_q <= '0;
      sense_err_q <= 1'b0;
      sense_en_q <= 1'b0;
      error_q <= 1'b0;
    end else begin
      err_latch_q <= err_latch_d;
      sense_err_q <= sense_bad | (sense_err_q & ~ack_any);
      sense_en_q <= sense_sync_q[1] & ~series_sync_q[1];
      error_q <= |err_latch_d;
    end
  end

  // set value path: master forwards, every unit takes its even share
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_q <= '0;
      out_vld_q <= 1'b0;
      share_q <= '0;
      unit_q <= '0;
    end else begin
      out_vld_q <= master_w & host_setval_vld;
      if (master_w && host_setval_vld) begin
        out_q <= host_setval;
        share_q <= host_setval;
      end else if (!master_w && link_setval_in_vld) begin
        share_q <= link_setval_in;
      end
      unit_q <= SETVAL_W'(share_q / units_w);
    end
  end

  // one engine per indicator; same code layout for both
  blink_engine #(
    .ON_CYC(ON_CYC),
    .OFF_CYC(OFF_CYC),
    .GGAP_CYC(GGAP_CYC),
    .CGAP_CYC(CGAP_CYC)
  ) u_red (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pending(err_pend),
    .led(red_led),
    .busy(),
    .cur_code()
  );

  blink_engine #(
    .ON_CYC(ON_CYC),
    .OFF_CYC(OFF_CYC),
    .GGAP_CYC(GGAP_CYC),
    .CGAP_CYC(CGAP_CYC)
  ) u_yellow (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pending(warn_cause),
    .led(yellow_led),
    .busy(),
    .cur_code()
  );

  assign link_setval_out = out_q;
  assign link_setval_out_vld = out_vld_q;
  assign unit_setval = unit_q;
  assign is_master = master_w;
  assign sense_enable = sense_en_q;
  assign sense_refused = sense_err_q;
  assign error_state = error_q;

  // an unacknowledged error state never drops on its own
  a_err_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (error_q && !ack_any) |=> error_q)
    else $error("error state dropped without acknowledge");
  // any present cause shows as error state one cycle later
  a_err_cause: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (|err_cause) |=> error_q)
    else $error("error state missing while cause present");
  // a held pin gives one edge only, so a level never acknowledges twice
  a_ext_edge: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ack_edge |=> !ack_edge)
    else $error("external acknowledge not a single edge");
  // a series sense request is refused and never enabled
  a_sense_ref: assert property (@(posedge sys_clk) disable iff (!arst_n)
    sense_bad |=> sense_err_q ##0 !sense_en_q)
    else $error("series sense request not refused");
  // the master passes a host value straight on
  a_fwd_setval: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (master_w && host_setval_vld) |=>
    (out_vld_q && out_q == $past(host_setval)))
    else $error("master did not forward set value");
  // the share lags the total by one cycle, so compare with the old total
  a_even_share: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (units_w == 7'h01 && $stable(share_q)) |=>
    unit_q == $past(share_q))
    else $error("single unit share differs from total");

  // an acknowledge with no cause left clears the error state
  a_ack_clear: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (ack_any && err_now == '0) |=> !error_q)
    else $error("acknowledge did not clear error state");

  // a refused sense request shows as an error
  a_sense_err: assert property (@(posedge sys_clk) disable iff (!arst_n)
    sense_err_q |=> error_q)
    else $error("sense refusal raised no error");

  // outside a series system a sense request is granted
  a_sense_grant: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (sense_sync_q[1] && !series_sync_q[1]) |=> sense_en_q)
    else $error("sense request not granted outside series");

  // slaves never drive the forward link
  a_slave_quiet: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !master_w |=> !out_vld_q)
    else $error("slave forwarded a set value");

  // the divisor stays between one and the bus limit
  a_unit_range: assert property (@(posedge sys_clk) disable iff (!arst_n)
    units_w != '0 && units_w <= 7'(flash_code_pkg::MAX_UNITS))
    else $error("unit count outside supported range");
endmodule
`default_nettype wire

// *** logic/flash_code_pkg.sv ***
// constants shared by the fault flash code indicator
package flash_code_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  // flash timing in milliseconds, converted to clock cycles below
  localparam int unsigned FLASH_ON_MS = 250;
  localparam int unsigned FLASH_OFF_MS = 250;
  localparam int unsigned GROUP_GAP_MS = 1000;
  localparam int unsigned CODE_GAP_MS = 2000;
  localparam int unsigned FLASH_ON_CYC = CLK_HZ / 1000 * FLASH_ON_MS;
  localparam int unsigned FLASH_OFF_CYC = CLK_HZ / 1000 * FLASH_OFF_MS;
  localparam int unsigned GROUP_GAP_CYC = CLK_HZ / 1000 * GROUP_GAP_MS;
  localparam int unsigned CODE_GAP_CYC = CLK_HZ / 1000 * CODE_GAP_MS;
  localparam int unsigned TIME_W = 26;
  // code space: 16 groups of 16 details, one pending bit per code
  localparam int unsigned NIBBLE_W = 4;
  localparam int unsigned CODE_W = 8;
  localparam int unsigned NUM_CODES = 256;
  // multi-unit bookkeeping
  localparam int unsigned MAX_UNITS = 64;
  localparam int unsigned UNIT_CNT_W = 7;
  localparam int unsigned SETVAL_W = 16;
endpackage

// *** logic/blink_engine.sv ***
// one led blink code engine: group burst, gap, detail burst, code gap
`timescale 1ns/100ps
`default_nettype none
module blink_engine #(
  parameter int unsigned ON_CYC = 4,
  parameter int unsigned OFF_CYC = 4,
  parameter int unsigned GGAP_CYC = 8,
  parameter int unsigned CGAP_CYC = 16
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [flash_code_pkg::NUM_CODES-1:0] pending,
  output logic led,
  output logic busy,
  output logic [flash_code_pkg::CODE_W-1:0] cur_code
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_GON, ST_GOFF, ST_GGAP, ST_DON, ST_DOFF, ST_CGAP
  } blink_st_t;
  localparam int unsigned TIME_W = flash_code_pkg::TIME_W;

  blink_st_t st_q, st_d;
  logic [flash_code_pkg::TIME_W-1:0] tmr_q, tmr_d;
  logic [flash_code_pkg::NIBBLE_W:0] cnt_q, cnt_d;
  logic [flash_code_pkg::CODE_W-1:0] code_q, code_d;
  logic led_q, led_d;
  logic [flash_code_pkg::CODE_W-1:0] next_code;
  logic found;
  wire tmr_done = (tmr_q == '0);
  wire [flash_code_pkg::NIBBLE_W:0] grp_flashes =
    {1'b0, code_q[7:4]} + 5'h01;
  wire [flash_code_pkg::NIBBLE_W:0] det_flashes =
    {1'b0, code_q[3:0]} + 5'h01;

  // search upward from the code after the current one, wrapping round,
  // so every pending code gets its turn before any repeats
  always_comb begin
    logic [flash_code_pkg::CODE_W-1:0] idx;
    idx = '0;
    next_code = '0;
    found = 1'b0;
    for (int i = 1; i <= flash_code_pkg::NUM_CODES; i++) begin
      idx = code_q + i[flash_code_pkg::CODE_W-1:0];
      if (!found && pending[idx]) begin
        found = 1'b1;
        next_code = idx;
      end
    end
  end

  // sequencer; one code is finished before the next is chosen
  always_comb begin
    st_d = st_q;
    tmr_d = tmr_done ? tmr_q : tmr_q - 1'b1;
    cnt_d = cnt_q;
    code_d = code_q;
    led_d = 1'b0;
    unique case (st_q)
      ST_IDLE: begin
        if (found) begin
          code_d = next_code;
          st_d = ST_GON;
          cnt_d = 5'h01;
          tmr_d = TIME_W'(ON_CYC - 1);
          led_d = 1'b1;
        end
      end
      ST_GON: begin
        led_d = !tmr_done;
        if (tmr_done) begin
          st_d = ST_GOFF;
          tmr_d = TIME_W'(OFF_CYC - 1);
        end
      end
      ST_GOFF: begin
        if (tmr_done) begin
          if (cnt_q == grp_flashes) begin
            st_d = ST_GGAP;
            tmr_d = TIME_W'(GGAP_CYC - 1);
          end else begin
            st_d = ST_GON;
            cnt_d = cnt_q + 5'h01;
            tmr_d = TIME_W'(ON_CYC - 1);
            led_d = 1'b1;
          end
        end
      end
      ST_GGAP: begin
        if (tmr_done) begin
          st_d = ST_DON;
          cnt_d = 5'h01;
          tmr_d = TIME_W'(ON_CYC - 1);
          led_d = 1'b1;
        end
      end
      ST_DON: begin
        led_d = !tmr_done;
        if (tmr_done) begin
          st_d = ST_DOFF;
          tmr_d = TIME_W'(OFF_CYC - 1);
        end
      end
      ST_DOFF: begin
        if (tmr_done) begin
          if (cnt_q == det_flashes) begin
            st_d = ST_CGAP;
            tmr_d = TIME_W'(CGAP_CYC - 1);
          end else begin
            st_d = ST_DON;
            cnt_d = cnt_q + 5'h01;
            tmr_d = TIME_W'(ON_CYC - 1);
            led_d = 1'b1;
          end
        end
      end
      ST_CGAP: begin
        if (tmr_done) begin
          st_d = ST_IDLE;
        end
      end
    endcase
  end

  // state registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_IDLE;
      tmr_q <= '0;
      cnt_q <= '0;
      code_q <= 8'hff;
      led_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      cnt_q <= cnt_d;
      code_q <= code_d;
      led_q <= led_d;
    end
  end

  assign led = led_q;
  assign busy = (st_q != ST_IDLE);
  assign cur_code = code_q;

  // a group flash burst never runs longer than the code asks for
  a_burst_len: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (st_q == ST_GOFF) |-> (cnt_q <= grp_flashes))
    else $error("group burst longer than code");
  a_gap_dark: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (st_q == ST_GGAP || st_q == ST_CGAP) |=> !led_q || st_q == ST_DON)
    else $error("led lit during gap");
  a_code_stable: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (st_q != ST_IDLE && st_q != ST_CGAP) |=> $stable(code_q))
    else $error("code changed mid presentation");
endmodule
`default_nettype wire

// *** testbench/flash_observer.sv ***
// observer model that counts the flashes of each burst on one led
`timescale 1ns/100ps
`default_nettype none
module flash_observer #(
  parameter int unsigned OFF_CYC = 4
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic led,
  output logic burst_done,
  output logic [4:0] burst_len
);
  logic [4:0] flash_q;
  logic [7:0] dark_q;
  logic led_q;
  // a dark run longer than one off time closes a burst, so the
  // short dark between flashes never splits a burst in two
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_q <= 5'h00;
      dark_q <= 8'h00;
      led_q <= 1'b0;
      burst_done <= 1'b0;
      burst_len <= 5'h00;
    end else begin
      led_q <= led;
      dark_q <= led ? 8'h00 : dark_q + 8'h01;
      burst_done <= 1'b0;
      if (led && !led_q) begin
        flash_q <= flash_q + 5'h01;
      end else if (!led && dark_q == OFF_CYC && flash_q != 5'h00) begin
        burst_done <= 1'b1;
        burst_len <= flash_q;
        flash_q <= 5'h00;
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/fault_flash_indicator_test.sv ***
// self-checking bench for the fault flash code indicator
`timescale 1ns/100ps
`default_nettype none
module fault_flash_indicator_test;
  logic sys_clk, arst_n, ack_button, ack_soft, ack_ext_pin;
  logic [255:0] err_cause, warn_cause;
  logic series_mode, sense_req, host_setval_vld, link_setval_in_vld;
  logic [3:0] upper_address_digit, lower_address_digit;
  logic [6:0] unit_count;
  logic [15:0] host_setval, link_setval_in, link_setval_out, unit_setval;
  logic link_setval_out_vld, is_master, sense_enable, sense_refused;
  logic error_state, red_led, yellow_led, burst_done;
  logic [4:0] burst_len;
  logic [6:0] cnt [5] = '{7'h01, 7'h00, 7'h07, 7'h40, 7'h64};
  logic [15:0] div [5] = '{16'h1, 16'h1, 16'h7, 16'h40, 16'h40};
  int failures = 0;
  int check_count = 0;

  // short timings so a whole code cycle fits in a few hundred cycles
  fault_flash_indicator #(.ON_CYC(4), .OFF_CYC(4), .GGAP_CYC(8),
    .CGAP_CYC(16)) dut (.sys_clk, .arst_n, .err_cause, .warn_cause,
    .ack_button, .ack_soft, .ack_ext_pin, .series_mode, .sense_req,
    .upper_address_digit, .lower_address_digit, .unit_count,
    .host_setval, .host_setval_vld, .link_setval_in, .link_setval_in_vld,
    .link_setval_out, .link_setval_out_vld, .unit_setval, .is_master,
    .sense_enable, .sense_refused, .error_state, .red_led, .yellow_led);
  flash_observer #(.OFF_CYC(4)) observer (.sys_clk, .arst_n,
    .led(yellow_led), .burst_done, .burst_len);

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [15:0] exp,
      input logic [15:0] seen);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic report_and_stop;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // warnings light only the yellow led and never latch an error
  task automatic warn_case;
    tick(1);
    warn_cause[35] <= 1'b1;
    tick(2);
    #1 check("yellow lit", 1, yellow_led);
    check("red dark", 0, red_led);
    check("no error", 0, error_state);
    warn_cause[35] <= 1'b0;
    tick(100);
    #1 check("yellow idle", 0, yellow_led);
    $display("warn test done");
  endtask

  task automatic setval_case(input logic [6:0] n, input logic [15:0] d);
    tick(1);
    unit_count <= n;
    host_setval <= 16'h9000;
    host_setval_vld <= 1'b1;
    tick(1);
    host_setval_vld <= 1'b0;
    #1 check("forward valid", 1, link_setval_out_vld);
    check("forward value", 16'h9000, link_setval_out);
    tick(1);
    #1 check("forward pulse", 0, link_setval_out_vld);
    check("share", 16'h9000 / d, unit_setval);
  endtask

  // master ignores the link, slaves ignore the host and take the link
  task automatic slave_case;
    tick(1);
    link_setval_in <= 16'h0c00;
    link_setval_in_vld <= 1'b1;
    tick(1);
    link_setval_in_vld <= 1'b0;
    tick(2);
    #1 check("master keeps", 16'h0240, unit_setval);
    check("master role", 1, is_master);
    upper_address_digit <= 4'h1;
    unit_count <= 7'h03;
    host_setval_vld <= 1'b1;
    link_setval_in_vld <= 1'b1;
    tick(1);
    host_setval_vld <= 1'b0;
    link_setval_in_vld <= 1'b0;
    #1 check("slave role", 0, is_master);
    check("slave no forward", 0, link_setval_out_vld);
    tick(2);
    #1 check("slave share", 16'h0400, unit_setval);
    upper_address_digit <= 4'h0;
    lower_address_digit <= 4'h5;
    #1 check("low digit slave", 0, is_master);
    $display("setval test done");
  endtask

  task automatic set_ack(input int src, input logic v);
    case (src)
      0: ack_soft <= v;
      1: ack_button <= v;
      default: ack_ext_pin <= v;
    endcase
  endtask

  // an ack during the fault or a level held high must not clear it
  // the button is a level, so it is only pulsed while the cause stands
  task automatic ack_case(input int src);
    tick(100); // let the red engine finish the previous code
    err_cause[35] <= 1'b1;
    set_ack(src, 1'b1);
    tick(1);
    if (src != 2) set_ack(src, 1'b0);
    #1 check("red lit", 1, red_led);
    tick(4);
    err_cause[35] <= 1'b0;
    tick(6);
    #1 check("error held", 1, error_state);
    if (src == 2) ack_ext_pin <= 1'b0;
    tick(3);
    set_ack(src, 1'b1);
    tick(1);
    if (src == 0) ack_soft <= 1'b0;
    tick(5);
    set_ack(src, 1'b0);
    #1 check("error cleared", 0, error_state);
    $display("ack test %0d done", src);
  endtask

  // code 0x23 was shown last, so the scan meets 0xf3 (16 and 4) first,
  // then wraps to 0x00 (1 and 1) and comes back to 0xf3
  task automatic blink_case;
    logic [4:0] want [6] = '{5'h10, 5'h04, 5'h01, 5'h01, 5'h10, 5'h04};
    int k;
    tick(1);
    warn_cause[8'h00] <= 1'b1;
    warn_cause[8'hf3] <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      k = 0;
      do begin
        @(posedge sys_clk);
        #1 k++;
      end while (!burst_done && k < 400);
      check("burst seen", 1, burst_done);
      check("burst length", want[i], burst_len);
    end
    warn_cause <= '0;
    $display("blink test done");
  endtask

  task automatic sense_case;
    tick(1);
    sense_req <= 1'b1;
    tick(5);
    #1 check("sense on", 1, sense_enable);
    check("no refusal", 0, sense_refused);
    series_mode <= 1'b1;
    tick(5);
    #1 check("sense off", 0, sense_enable);
    check("refused", 1, sense_refused);
    check("refusal error", 1, error_state);
    $display("sense test done");
  endtask

  initial begin
    {ack_button, ack_soft, ack_ext_pin, series_mode, sense_req} = '0;
    {err_cause, warn_cause, host_setval_vld} = '0;
    {upper_address_digit, lower_address_digit, unit_count} = '0;
    {host_setval, link_setval_in, link_setval_in_vld} = '0;
    arst_n = 1'b0;
    tick(2);
    arst_n <= 1'b1;
    #1 check("reset error", 0, error_state);
    warn_case();
    for (int i = 0; i < 5; i++) begin
      setval_case(cnt[i], div[i]);
    end
    slave_case();
    for (int s = 0; s < 3; s++) begin
      ack_case(s);
    end
    blink_case();
    sense_case();
    report_and_stop();
  end

  // the tests need under two thousand cycles
  initial begin
    #200000;
    failures++;
    report_and_stop();
  end
endmodule
`default_nettype wire
